// ### src/bridge_cfg_pkg.sv
// constants and carrier types for the bridge configuration header block
package bridge_cfg_pkg;
    localparam logic [11:0] MAKER_CODE_OFF    = 12'h000;
    localparam logic [11:0] PART_CODE_OFF     = 12'h002;
    localparam logic [11:0] CMD_WORD_OFF      = 12'h004;
    localparam logic [11:0] STATUS_OFF        = 12'h006;
    localparam logic [15:0] CMD_RESET         = 16'h0000;
    localparam logic [15:0] CMD_WRITE_MASK    = 16'h0547;
    localparam int          IO_DECODE_BIT     = 0;
    localparam int          MEM_DECODE_BIT    = 1;
    localparam int          BUS_MASTER_BIT    = 2;
    localparam int          POISON_REPORT_BIT = 6;
    localparam int          ERROR_REPORT_BIT  = 8;
    localparam int          LEGACY_IRQ_BIT    = 10;
    localparam int          IRQ_PENDING_BIT   = 3;
    localparam int          CAP_LIST_BIT      = 4;
    localparam int          POISON_SEEN_BIT   = 8;
    localparam int          SYS_ERR_SENT_BIT  = 14;
    localparam logic        STATUS_FLAG_RESET = 1'b0;
    localparam int          RSP_LATENCY       = 1;

    typedef enum logic [1:0] {
        KIND_MEM   = 2'b00,
        KIND_IO    = 2'b01,
        KIND_OTHER = 2'b10,
        KIND_CPL   = 2'b11
    } req_kind_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic      valid;
        req_kind_t kind;
        logic      non_posted;
    } sec_req_t;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
    } err_pair_t;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic correctable;
    } err_msg_t;
endpackage : bridge_cfg_pkg

// ### src/bridge_config_header_command.sv
// type 1 header identification words, command register and two status flags
// Function
// R1 - offset 0x000 reads a fixed 16-bit maker code; writes ignored
// R2 - offset 0x002 reads a fixed 16-bit part code; writes ignored
// R3 - command bit 0 resets low; when low primary io window accesses are ignored
// R4 - command bit 1 resets low; when low primary memory window accesses are ignored
// R5 - bit 2 low: no mem/io requests forwarded for subordinates; non-posted get UR
// R6 - bit 2 never affects completions or non memory, non io requests
// R7 - bit 6 set: poisoned completion or write sets poisoned_data_seen; else never
// R8 - own fatal/nonfatal errors reported only if bit 8 or device-control enable set
// R9 - bit 8 gates forwarding fatal/nonfatal messages; correctable always forwarded
// R10 - bit 10 set negates own legacy interrupts; resets low
// R11 - bit 10 leaves forwarded legacy interrupts untouched
// R12 - unused command bits and bits 15 to 11 read zero and ignore writes
// R13 - poisoned_data_seen is status bit 8, resets low, write one clears
// R14 - status bit 14 sets on sending fatal/nonfatal message with bit 8 set; w1c
// R15 - id writes complete harmlessly; command writes act on the next request
`timescale 1ns/1ps
module bridge_config_header_command
    import bridge_cfg_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h5a5a,  // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h0c3d   // arbitrary value
) (
    input  wire logic      core_clk_i,
    input  wire logic      arst_n_i,
    input  wire cfg_req_t  cfg_req_i,
    output cfg_rsp_t       cfg_rsp_o,
    input  wire logic      pri_io_hit_i,
    input  wire logic      pri_mem_hit_i,
    output logic           io_claim_o,
    output logic           mem_claim_o,
    input  wire sec_req_t  sec_req_i,
    output logic           sec_fwd_o,
    output logic           sec_ur_o,
    input  wire logic      poisoned_cpl_i,
    input  wire logic      poisoned_wr_i,
    input  wire err_pair_t own_err_i,
    input  wire err_pair_t dev_ctl_report_en_i,
    output err_pair_t      own_err_msg_o,
    input  wire err_msg_t  sec_err_msg_i,
    output err_msg_t       fwd_err_msg_o,
    input  wire logic      own_irq_i,
    input  wire logic      sec_irq_i,
    output logic           own_irq_o,
    output logic           fwd_irq_o
);
    typedef struct packed {
        logic [15:0] cmd;
        logic        poison_seen;
        logic        sys_err_sent;
        logic        irq_pend;
        cfg_rsp_t    rsp;
        logic        io_claim;
        logic        mem_claim;
        logic        sec_fwd;
        logic        sec_ur;
        err_pair_t   own_msg;
        err_msg_t    fwd_msg;
        logic        own_irq;
        logic        fwd_irq;
    } state_t;

    state_t s;
    state_t next_s;

    logic [15:0] status_word;
    logic        mem_or_io;
    logic        cmd_hit;
    logic        status_w1c;

    always_comb begin
        next_s      = s;
        status_word = 16'h0000;
        status_word[CAP_LIST_BIT]     = 1'b1;
        status_word[IRQ_PENDING_BIT]  = s.irq_pend;
        status_word[POISON_SEEN_BIT]  = s.poison_seen;
        status_word[SYS_ERR_SENT_BIT] = s.sys_err_sent;
        cmd_hit    = cfg_req_i.valid && cfg_req_i.offset[11:2] == CMD_WORD_OFF[11:2];
        status_w1c = cmd_hit && cfg_req_i.write && cfg_req_i.byte_en[3];

        // configuration access, answered one cycle later
        next_s.rsp.valid = cfg_req_i.valid;
        next_s.rsp.rdata = 32'h0000_0000;
        if (cfg_req_i.valid && !cfg_req_i.write) begin
            if (cfg_req_i.offset[11:2] == MAKER_CODE_OFF[11:2]) begin
                next_s.rsp.rdata = {PART_CODE, MAKER_CODE}; // R1 R2
            end else if (cmd_hit) begin
                next_s.rsp.rdata = {status_word, s.cmd & CMD_WRITE_MASK}; // R12
            end
        end
        if (cmd_hit && cfg_req_i.write) begin
            if (cfg_req_i.byte_en[0]) begin
                next_s.cmd[7:0] = cfg_req_i.wdata[7:0] & CMD_WRITE_MASK[7:0]; // R12 R15
            end
            if (cfg_req_i.byte_en[1]) begin
                next_s.cmd[15:8] = cfg_req_i.wdata[15:8] & CMD_WRITE_MASK[15:8]; // R12
            end
        end

        // status flags: write one clears, a same-cycle event wins
        if (status_w1c && cfg_req_i.wdata[16 + POISON_SEEN_BIT]) begin
            next_s.poison_seen = 1'b0; // R13
        end
        if (status_w1c && cfg_req_i.wdata[16 + SYS_ERR_SENT_BIT]) begin
            next_s.sys_err_sent = 1'b0; // R14
        end
        if (s.cmd[POISON_REPORT_BIT] && (poisoned_cpl_i || poisoned_wr_i)) begin
            next_s.poison_seen = 1'b1; // R7 R13
        end

        // primary window decode
        next_s.io_claim  = pri_io_hit_i && s.cmd[IO_DECODE_BIT]; // R3
        next_s.mem_claim = pri_mem_hit_i && s.cmd[MEM_DECODE_BIT]; // R4

        // subordinate requests
        mem_or_io      = sec_req_i.kind == KIND_MEM || sec_req_i.kind == KIND_IO;
        next_s.sec_fwd = sec_req_i.valid && (!mem_or_io || s.cmd[BUS_MASTER_BIT]); // R5 R6
        next_s.sec_ur  = sec_req_i.valid && mem_or_io && !s.cmd[BUS_MASTER_BIT]
                         && sec_req_i.non_posted; // R5

        // error messages
        next_s.own_msg.fatal    = own_err_i.fatal
                                  && (s.cmd[ERROR_REPORT_BIT] || dev_ctl_report_en_i.fatal); // R8
        next_s.own_msg.nonfatal = own_err_i.nonfatal
                                  && (s.cmd[ERROR_REPORT_BIT] || dev_ctl_report_en_i.nonfatal); // R8
        next_s.fwd_msg.correctable = sec_err_msg_i.correctable; // R9
        next_s.fwd_msg.fatal       = sec_err_msg_i.fatal && s.cmd[ERROR_REPORT_BIT]; // R9
        next_s.fwd_msg.nonfatal    = sec_err_msg_i.nonfatal && s.cmd[ERROR_REPORT_BIT]; // R9
        if (s.cmd[ERROR_REPORT_BIT] && (next_s.own_msg.fatal || next_s.own_msg.nonfatal
                || next_s.fwd_msg.fatal || next_s.fwd_msg.nonfatal)) begin
            next_s.sys_err_sent = 1'b1; // R14
        end

        // legacy interrupts
        next_s.irq_pend = own_irq_i;
        next_s.own_irq  = own_irq_i && !s.cmd[LEGACY_IRQ_BIT]; // R10
        next_s.fwd_irq  = sec_irq_i; // R11
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s              <= '0;
            s.cmd          <= CMD_RESET; // R3 R4 R5 R10
            s.poison_seen  <= STATUS_FLAG_RESET; // R13
            s.sys_err_sent <= STATUS_FLAG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign cfg_rsp_o     = s.rsp;
    assign io_claim_o    = s.io_claim;
    assign mem_claim_o   = s.mem_claim;
    assign sec_fwd_o     = s.sec_fwd;
    assign sec_ur_o      = s.sec_ur;
    assign own_err_msg_o = s.own_msg;
    assign fwd_err_msg_o = s.fwd_msg;
    assign own_irq_o     = s.own_irq;
    assign fwd_irq_o     = s.fwd_irq;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    id_read_fixed_a: assert property ( // R1
        cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.offset == MAKER_CODE_OFF
        |=> cfg_rsp_o.valid && cfg_rsp_o.rdata == {PART_CODE, MAKER_CODE})
        else $error("identification word read wrong");
    id_write_ignored_a: assert property ( // R2
        cfg_req_i.valid && cfg_req_i.write && cfg_req_i.offset[11:2] == PART_CODE_OFF[11:2]
        |=> cfg_rsp_o.valid && s.cmd == $past(s.cmd))
        else $error("identification write disturbed state");
    io_gate_a: assert property ( // R3
        pri_io_hit_i && !s.cmd[IO_DECODE_BIT] |=> !io_claim_o)
        else $error("io access claimed while io decode off");
    mem_gate_a: assert property ( // R4
        pri_mem_hit_i |=> mem_claim_o == $past(s.cmd[MEM_DECODE_BIT]))
        else $error("memory claim does not follow memory decode enable");
    master_ur_a: assert property ( // R5
        sec_req_i.valid && sec_req_i.non_posted && sec_req_i.kind == KIND_IO
        && !s.cmd[BUS_MASTER_BIT] |=> sec_ur_o && !sec_fwd_o)
        else $error("non-posted io not refused with bus master off");
    cpl_pass_a: assert property ( // R6
        sec_req_i.valid && sec_req_i.kind == KIND_CPL |=> sec_fwd_o && !sec_ur_o)
        else $error("completion blocked by bus master bit");
    poison_never_a: assert property ( // R7
        !s.cmd[POISON_REPORT_BIT] && !s.poison_seen |=> !s.poison_seen)
        else $error("poison flag set while reporting disabled");
    own_err_gate_a: assert property ( // R8
        own_err_i.fatal |=> own_err_msg_o.fatal ==
        $past(s.cmd[ERROR_REPORT_BIT] || dev_ctl_report_en_i.fatal))
        else $error("fatal error report gating wrong");
    cor_forward_a: assert property ( // R9
        sec_err_msg_i.correctable |=> fwd_err_msg_o.correctable)
        else $error("correctable message not forwarded");
    irq_disable_a: assert property ( // R10
        s.cmd[LEGACY_IRQ_BIT] && $stable(s.cmd[LEGACY_IRQ_BIT]) |-> !own_irq_o)
        else $error("own interrupt asserted while disabled");
    fwd_irq_a: assert property ( // R11
        sec_irq_i |=> fwd_irq_o)
        else $error("forwarded interrupt lost");
    reserved_zero_a: assert property ( // R12
        (s.cmd & ~CMD_WRITE_MASK) == 16'h0000)
        else $error("read-only command bit became set");
    poison_set_wins_a: assert property ( // R13
        s.cmd[POISON_REPORT_BIT] && poisoned_cpl_i |=> s.poison_seen)
        else $error("poison event lost");
    sys_err_set_a: assert property ( // R14
        s.cmd[ERROR_REPORT_BIT] && sec_err_msg_i.fatal |=> s.sys_err_sent [*1] ##0 fwd_err_msg_o.fatal)
        else $error("system error sent flag missed");
    cmd_next_req_a: assert property ( // R15
        cmd_hit && cfg_req_i.write && cfg_req_i.byte_en[0] |=> cfg_rsp_o.valid
        && s.cmd[IO_DECODE_BIT] == $past(cfg_req_i.wdata[IO_DECODE_BIT]))
        else $error("command write not in effect for next request");

    // configuration answers
    cfg_answer_a: assert property ( // R15
        cfg_req_i.valid |=> cfg_rsp_o.valid)
        else $error("configuration request not answered");
    cfg_quiet_a: assert property ( // R15
        !cfg_req_i.valid |=> !cfg_rsp_o.valid)
        else $error("answer without a request");
    write_rdata_zero_a: assert property ( // R15
        cfg_req_i.valid && cfg_req_i.write |=> cfg_rsp_o.rdata == 32'h0000_0000)
        else $error("write answered with data");
    part_read_a: assert property ( // R2
        cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.offset[11:2] == PART_CODE_OFF[11:2]
        |=> cfg_rsp_o.rdata[31:16] == PART_CODE)
        else $error("part code read wrong");
    cmd_read_a: assert property ( // R12
        cmd_hit && !cfg_req_i.write |=> cfg_rsp_o.rdata[15:0] == $past(s.cmd))
        else $error("command read does not match stored value");
    reserved_read_a: assert property ( // R12
        cmd_hit && !cfg_req_i.write |=> (cfg_rsp_o.rdata[15:0] & ~CMD_WRITE_MASK) == 16'h0000)
        else $error("read-only command bit read as one");
    status_read_a: assert property ( // R13
        cmd_hit && !cfg_req_i.write
        |=> cfg_rsp_o.rdata[16 + POISON_SEEN_BIT] == $past(s.poison_seen))
        else $error("status read does not show poisoned data flag");
    cmd_high_write_a: assert property ( // R12 R15
        cmd_hit && cfg_req_i.write && cfg_req_i.byte_en[1]
        |=> s.cmd[15:8] == ($past(cfg_req_i.wdata[15:8]) & CMD_WRITE_MASK[15:8]))
        else $error("command high byte write wrong");
    cmd_keep_a: assert property ( // R15
        !(cmd_hit && cfg_req_i.write) |=> s.cmd == $past(s.cmd))
        else $error("command changed without a command write");

    // primary decode
    io_claim_a: assert property ( // R3
        pri_io_hit_i && s.cmd[IO_DECODE_BIT] |=> io_claim_o)
        else $error("enabled io access not claimed");
    io_idle_a: assert property ( // R3
        !pri_io_hit_i |=> !io_claim_o)
        else $error("io claim without a hit");
    mem_idle_a: assert property ( // R4
        !pri_mem_hit_i |=> !mem_claim_o)
        else $error("memory claim without a hit");

    // subordinate requests
    master_fwd_a: assert property ( // R5 R6
        sec_req_i.valid && s.cmd[BUS_MASTER_BIT] |=> sec_fwd_o && !sec_ur_o)
        else $error("request not forwarded with bus master on");
    mem_ur_a: assert property ( // R5
        sec_req_i.valid && sec_req_i.non_posted && sec_req_i.kind == KIND_MEM
        && !s.cmd[BUS_MASTER_BIT] |=> sec_ur_o && !sec_fwd_o)
        else $error("non-posted memory not refused with bus master off");
    posted_drop_a: assert property ( // R5
        sec_req_i.valid && !sec_req_i.non_posted && sec_req_i.kind == KIND_MEM
        && !s.cmd[BUS_MASTER_BIT] |=> !sec_fwd_o && !sec_ur_o)
        else $error("posted memory request leaked with bus master off");
    other_pass_a: assert property ( // R6
        sec_req_i.valid && sec_req_i.kind == KIND_OTHER |=> sec_fwd_o && !sec_ur_o)
        else $error("non memory, non io request blocked");
    sec_idle_a: assert property ( // R5
        !sec_req_i.valid |=> !sec_fwd_o && !sec_ur_o)
        else $error("subordinate output without a request");

    // poisoned data flag
    poison_wr_a: assert property ( // R7
        s.cmd[POISON_REPORT_BIT] && poisoned_wr_i |=> s.poison_seen)
        else $error("poisoned write not flagged");
    poison_clear_a: assert property ( // R13
        status_w1c && cfg_req_i.wdata[16 + POISON_SEEN_BIT] && !poisoned_cpl_i && !poisoned_wr_i
        |=> !s.poison_seen)
        else $error("poisoned data flag not cleared");
    poison_hold_a: assert property ( // R13
        s.poison_seen && !status_w1c |=> s.poison_seen)
        else $error("poisoned data flag lost");

    // error messages
    own_nonfatal_gate_a: assert property ( // R8
        own_err_i.nonfatal |=> own_err_msg_o.nonfatal ==
        $past(s.cmd[ERROR_REPORT_BIT] || dev_ctl_report_en_i.nonfatal))
        else $error("non-fatal error report gating wrong");
    own_quiet_a: assert property ( // R8
        !own_err_i.fatal && !own_err_i.nonfatal |=> own_err_msg_o == 2'b00)
        else $error("error message without an error");
    fwd_gate_a: assert property ( // R9
        sec_err_msg_i.fatal |=> fwd_err_msg_o.fatal == $past(s.cmd[ERROR_REPORT_BIT]))
        else $error("fatal message forwarding gating wrong");
    fwd_nonfatal_a: assert property ( // R9
        sec_err_msg_i.nonfatal |=> fwd_err_msg_o.nonfatal == $past(s.cmd[ERROR_REPORT_BIT]))
        else $error("non-fatal message forwarding gating wrong");
    sys_err_quiet_a: assert property ( // R14
        !s.cmd[ERROR_REPORT_BIT] && !s.sys_err_sent |=> !s.sys_err_sent)
        else $error("system error flag set while reporting off");
    sys_err_own_a: assert property ( // R14
        s.cmd[ERROR_REPORT_BIT] && own_err_i.nonfatal |=> s.sys_err_sent)
        else $error("own error message did not set system error flag");

    // legacy interrupts
    irq_pass_a: assert property ( // R10
        own_irq_i && !s.cmd[LEGACY_IRQ_BIT] |=> own_irq_o)
        else $error("enabled own interrupt not raised");
    irq_masked_a: assert property ( // R10
        own_irq_i && s.cmd[LEGACY_IRQ_BIT] |=> !own_irq_o)
        else $error("own interrupt raised while disabled");
    fwd_irq_low_a: assert property ( // R11
        !sec_irq_i |=> !fwd_irq_o)
        else $error("forwarded interrupt without a source");

    cmd_write_c: cover property (cmd_hit && cfg_req_i.write ##1 pri_mem_hit_i ##1 mem_claim_o);
    ur_seen_c: cover property (sec_ur_o);
    poison_clear_c: cover property (s.poison_seen ##1 !s.poison_seen);
    sys_err_seen_c: cover property (s.sys_err_sent && own_err_msg_o.nonfatal);
    irq_masked_c: cover property (s.cmd[LEGACY_IRQ_BIT] && own_irq_i);
endmodule : bridge_config_header_command

// ### tb/cfg_host_model.sv
// behavioural root complex that issues configuration requests
`timescale 1ns/1ps
module cfg_host_model
    import bridge_cfg_pkg::*;
(
    input  wire logic     core_clk_i,
    output cfg_req_t      cfg_req_o,
    input  wire cfg_rsp_t cfg_rsp_i
);
    initial cfg_req_o = '0;
    // one request after an optional idle gap; idle fields show inverted values
    task automatic access(input logic wr, input logic [11:0] off, input logic [3:0] be,
                          input logic [31:0] wd, input int gap,
                          output logic [31:0] rd, output logic ok);
        repeat (gap) @(posedge core_clk_i);
        @(posedge core_clk_i);
        cfg_req_o <= '{valid: 1'b1, write: wr, offset: off, byte_en: be, wdata: wd};
        @(posedge core_clk_i);
        cfg_req_o <= '{valid: 1'b0, write: ~wr, offset: ~off, byte_en: ~be, wdata: ~wd};
        @(posedge core_clk_i);
        ok = (cfg_rsp_i.valid === 1'b1);
        rd = cfg_rsp_i.rdata;
    endtask : access
endmodule : cfg_host_model

// ### tb/testbench.sv
// self-checking bench for the bridge configuration header block
`timescale 1ns/1ps
module testbench;
    import bridge_cfg_pkg::*;
    typedef struct packed {
        logic io_hit; logic mem_hit; sec_req_t sec; logic p_cpl; logic p_wr;
        err_pair_t own; err_pair_t dev; err_msg_t sec_err; logic own_irq; logic sec_irq;
    } ev_t;
    localparam logic [15:0] MAKER = 16'h3c96;  // arbitrary value
    localparam logic [15:0] PART  = 16'h7e21;  // arbitrary value
    logic        core_clk_i = 1'b0;
    logic        arst_n_i   = 1'b0;
    ev_t         ev         = '0;
    cfg_req_t    cfg_req;
    cfg_rsp_t    cfg_rsp;
    wire [10:0]  outs;
    logic [15:0] cmd;
    logic [31:0] rd, wd;
    logic [3:0]  be;
    logic        ps, ss;
    int          n_mismatch = 0, compares = 0, cycles = 0;
    always #50 core_clk_i = ~core_clk_i;
    cfg_host_model cfg_host_model_i (.core_clk_i(core_clk_i), .cfg_req_o(cfg_req),
                                     .cfg_rsp_i(cfg_rsp));
    bridge_config_header_command #(.MAKER_CODE(MAKER), .PART_CODE(PART))
        bridge_config_header_command_i (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cfg_req_i(cfg_req),
        .cfg_rsp_o(cfg_rsp), .pri_io_hit_i(ev.io_hit), .pri_mem_hit_i(ev.mem_hit),
        .io_claim_o(outs[10]), .mem_claim_o(outs[9]), .sec_req_i(ev.sec),
        .sec_fwd_o(outs[8]), .sec_ur_o(outs[7]), .poisoned_cpl_i(ev.p_cpl),
        .poisoned_wr_i(ev.p_wr), .own_err_i(ev.own), .dev_ctl_report_en_i(ev.dev),
        .own_err_msg_o(outs[6:5]), .sec_err_msg_i(ev.sec_err), .fwd_err_msg_o(outs[4:2]),
        .own_irq_i(ev.own_irq), .sec_irq_i(ev.sec_irq), .own_irq_o(outs[1]),
        .fwd_irq_o(outs[0]));
    task automatic end_sim;
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            end_sim();
        end
    end
    function automatic logic [15:0] stat();
        return {1'b0, ss, 5'h00, ps, 3'h0, 1'b1, 4'h0};
    endfunction : stat
    function automatic logic [10:0] exp_out(ev_t e, logic [15:0] c);
        logic mi;
        mi = (e.sec.kind == KIND_MEM) || (e.sec.kind == KIND_IO);
        return {e.io_hit & c[0], e.mem_hit & c[1], e.sec.valid & (~mi | c[2]),
                e.sec.valid & mi & e.sec.non_posted & ~c[2],
                e.own & (e.dev | {2{c[8]}}), e.sec_err & {c[8], c[8], 1'b1},
                e.own_irq & ~c[10], e.sec_irq};
    endfunction : exp_out
    task automatic cfg(input logic wr, input logic [11:0] off, input logic [3:0] b,
                       input logic [31:0] w, output logic [31:0] r);
        logic ok;
        cfg_host_model_i.access(wr, off, b, w, $urandom_range(2), r, ok);
        check({31'h0, ok}, 32'h1, "config answer");
    endtask : cfg
    // one event cycle: inputs sampled once, outputs checked one cycle later
    task automatic step();
        ev_t e;
        e = ev_t'(17'($urandom));
        @(posedge core_clk_i);
        ev <= e;
        @(posedge core_clk_i);
        ev <= '0;
        #1 check({21'h0, outs}, {21'h0, exp_out(e, cmd)}, "event path");
        ps = ps | (cmd[6] & (e.p_cpl | e.p_wr));
        ss = ss | (cmd[8] & (|e.own | e.sec_err.fatal | e.sec_err.nonfatal));
    endtask : step
    initial begin
        cmd = CMD_RESET;
        ps = 1'b0;
        ss = 1'b0;
        void'($urandom(80757));
        repeat (12) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        cfg(1'b0, MAKER_CODE_OFF, 4'hf, 32'h0, rd);
        check(rd, {PART, MAKER}, "id words");
        cfg(1'b0, CMD_WORD_OFF, 4'hf, 32'h0, rd);
        check(rd, {stat(), 16'h0000}, "reset command");
        cfg(1'b1, MAKER_CODE_OFF, 4'hf, $urandom, rd);
        cfg(1'b0, PART_CODE_OFF, 4'hf, 32'h0, rd);
        check(rd, {PART, MAKER}, "id after write");
        cfg(1'b0, 12'h010, 4'hf, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        $display("test registers done");
        for (int i = 0; i < 300; i++) begin
            if (i % 8 == 0) begin
                wd = (i == 0) ? 32'hffffffff : (i == 8) ? 32'h0 : $urandom;
                be = (i < 16) ? 4'hf : 4'($urandom);
                cfg(1'b1, CMD_WORD_OFF, be, wd, rd);
                for (int k = 0; k < 2; k++) begin
                    if (be[k]) cmd[k*8 +: 8] = wd[k*8 +: 8] & CMD_WRITE_MASK[k*8 +: 8];
                end
                if (be[3] && wd[24]) ps = 1'b0;
                if (be[3] && wd[30]) ss = 1'b0;
                cfg(1'b0, CMD_WORD_OFF, 4'hf, 32'h0, rd);
                check(rd, {stat(), cmd}, "command and status");
            end
            step();
        end
        cfg(1'b0, CMD_WORD_OFF, 4'hf, 32'h0, rd);
        check(rd, {stat(), cmd}, "final status");
        $display("test random events done");
        end_sim();
    end
endmodule : testbench
